// ---- core/cache_seq_pkg.sv ----
package cache_seq_pkg;
	// address numbering: bit 0 is the most significant
	localparam int TAG_FIRST   = 5;
	localparam int TAG_LAST    = 20;
	localparam int INDEX_FIRST = 21;
	localparam int INDEX_LAST  = 28;
	localparam int DSET_LAST   = 30;
	localparam int WORD_SEL    = 31;
	localparam int TAG_W       = 16;
	localparam int INDEX_W     = 8;
	localparam int DSET_W      = 10;
	localparam int BLOCKS      = 256;
	localparam int DSET_DEPTH  = 1024;
	localparam int CPU_W       = 16;
	localparam logic [1:0] WORD_CNT_LAST = 2'h3;

	typedef enum logic [1:0] {
		cache_idle_state    = 2'b00,
		wait_for_bus_state  = 2'b01,
		receive_block_state = 2'b11,
		send_block_state    = 2'b10
	} cache_state_t;

	typedef enum logic [1:0] {
		bus_op_none           = 2'b00,
		read_block_private_op = 2'b01,
		write_old_block_op    = 2'b10
	} bus_op_t;

	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_HITS   = 8'h08;
	localparam logic [7:0] OFF_MISSES = 8'h0C;
	localparam int CTRL_PARITY_EN = 0;
	localparam logic CTRL_PARITY_RESET = 1'b1;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CNT_LSB   = 2;
	localparam int STAT_FAIL      = 4;
	localparam int STAT_PAR_ERR   = 5;
	localparam int STAT_DUAL_HIT  = 6;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cache_seq_pkg

// ---- core/cache_hit_fault_sequencer.sv ----
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// R01: reads keep all write enables high; write hit, bit 31 high drives lower enable
// R02: both data sets addressed by address bits 21..30, one double-word each
// R03: read hit with bit ten high returns hit set lower word to CPU
// R04: parity of returned word checked; error shown to CPU
// R05: fail low at sample edge lets CPU finish access and drop start
// R06: CPU write in idle selects CPU write bus as RAM data
// R07: bits 21-28 pick block; clean miss refills least recent block
// R08: miss raises fail; CPU holds start and write until done
// R09: fail in idle goes wait-for-bus; clean miss issues read op and wake
// R10: wait-for-bus drives full request address onto outgoing bus
// R11: grant on clean miss enters receive, RAM address from word counter
// R12: receive state with victim set drives its write enables active
// R13: first refill word comes nine or more cycles after grant
// R14: ready becomes strobe; counts words and enables interface register
// R15: bus unit holds ready asserted until the block is complete
// R16: counter steps 0..3; terminal count returns to idle
// R17: refill marks block valid in the cache
// R18: back in idle, pending CPU access completes
// R19: dirty miss writes old block back, then refills
// R20: dirty victim in wait-for-bus issues write-old-block op
// R21: grant with dirty victim enters send state
// R22: entering send sets write-back set select toward the victim set
// R23: per-block 16-bit tag from bits 5-20 compared each access
// R24: tag match in both sets raises cache error
// R25: write hit marks block modified
module cache_hit_fault_sequencer
	import cache_seq_pkg::*;
(
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	input  wire logic [cache_seq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                             s_axi_awvalid,
	output logic                                  s_axi_awready,
	input  wire logic [31:0]                      s_axi_wdata,
	input  wire logic [3:0]                       s_axi_wstrb,
	input  wire logic                             s_axi_wvalid,
	output logic                                  s_axi_wready,
	output logic [1:0]                            s_axi_bresp,
	output logic                                  s_axi_bvalid,
	input  wire logic                             s_axi_bready,
	input  wire logic [cache_seq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                             s_axi_arvalid,
	output logic                                  s_axi_arready,
	output logic [31:0]                           s_axi_rdata,
	output logic [1:0]                            s_axi_rresp,
	output logic                                  s_axi_rvalid,
	input  wire logic                             s_axi_rready,
	input  wire logic                             cpu_sample_clock,
	input  wire logic                             cpu_start,
	input  wire logic                             cpu_write,
	input  wire logic [0:31]                      cpu_addr,
	input  wire logic [cache_seq_pkg::CPU_W-1:0]  cpu_write_bus,
	output logic [cache_seq_pkg::CPU_W-1:0]       cpu_read_bus,
	output logic                                  cpu_fail,
	output logic                                  cpu_parity_error,
	output logic                                  cache_error,
	input  wire logic                             bus_grant_ack,
	input  wire logic                             refill_word_ready,
	input  wire logic [31:0]                      refill_bus,
	output cache_seq_pkg::bus_op_t                bus_op,
	output logic                                  wake_req_n,
	output logic [0:31]                           outgoing_data,
	output logic                                  writeback_word_valid,
	output logic                                  writeback_set_select,
	output logic                                  interface_reg_output_enable_n,
	output logic                                  refill_word_strobe,
	output logic                                  word_count_terminal,
	output logic                                  set_a_upper_write_en_n,
	output logic                                  set_a_lower_write_en_n,
	output logic                                  set_b_upper_write_en_n,
	output logic                                  set_b_lower_write_en_n
);
	import cache_seq_pkg::*;

	// ==================================================
	// state and decode
	cache_state_t           state_reg;
	logic [1:0]             word_cnt_reg;
	logic                   fail_reg;
	logic                   samp_s1_reg;
	logic                   samp_s2_reg;
	logic                   samp_s3_reg;
	logic                   sample_edge;
	logic [BLOCKS-1:0]      lru_a_reg;
	logic                   wb_sel_reg;
	logic                   parity_en_reg;
	logic [31:0]            hit_cnt_reg;
	logic [31:0]            miss_cnt_reg;
	logic [INDEX_W-1:0]     index;
	logic [TAG_W-1:0]       tag_in;
	logic [DSET_W-1:0]      ram_addr;
	logic [1:0]             hit;
	logic [1:0]             blk_dirty;
	logic [1:0][16:0]       rd_up;
	logic [1:0][16:0]       rd_lo;
	logic [1:0]             up_we_n;
	logic [1:0]             lo_we_n;
	logic                   miss;
	logic                   dual_hit;
	logic                   hit_set;
	logic                   victim_set;
	logic                   victim_dirty;
	logic                   in_idle;
	logic                   do_access;
	logic                   wr_hit_go;
	logic                   fill_go;
	logic                   use_cpu_bus;
	logic [16:0]            word_out;
	logic [16:0]            wdata_up;
	logic [16:0]            wdata_lo;

	// the sample clock is foreign: two flops, then edge detect on the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp_s1_reg <= 1'b0;
			samp_s2_reg <= 1'b0;
			samp_s3_reg <= 1'b0;
		end else begin
			samp_s1_reg <= cpu_sample_clock;
			samp_s2_reg <= samp_s1_reg;
			samp_s3_reg <= samp_s2_reg;
		end
	end
	assign sample_edge = samp_s2_reg & ~samp_s3_reg;

	// R23: tag and block index
	assign index  = cpu_addr[INDEX_FIRST:INDEX_LAST];
	assign tag_in = cpu_addr[TAG_FIRST:TAG_LAST];
	assign in_idle = (state_reg == cache_idle_state);
	assign miss = ~(hit[0] | hit[1]);
	// R24: both sets matching
	assign dual_hit = hit[0] & hit[1];
	assign hit_set = ~hit[0];
	// R07: victim is the least recent block of the index
	assign victim_set = ~lru_a_reg[index];
	assign victim_dirty = blk_dirty[victim_set];

	// R02: double-word address, word counter during transfers
	always_comb begin
		if (in_idle || state_reg == wait_for_bus_state) begin
			ram_addr = cpu_addr[INDEX_FIRST:DSET_LAST];
		end else begin
			// R11: counted word inside the block
			ram_addr = {index, word_cnt_reg};
		end
	end

	// R05: access completes only with fail low at the sample edge
	assign do_access = in_idle & cpu_start & ~fail_reg & ~miss & sample_edge;
	assign wr_hit_go = do_access & cpu_write;
	// R14: ready turns into the strobe only while receiving
	assign refill_word_strobe = refill_word_ready & (state_reg == receive_block_state);
	assign interface_reg_output_enable_n = ~refill_word_strobe;
	assign fill_go = refill_word_strobe;

	// R06: CPU write bus feeds the RAMs for writes while idle
	assign use_cpu_bus = cpu_write & in_idle;
	assign wdata_up = use_cpu_bus ? {^cpu_write_bus, cpu_write_bus}
		: {^refill_bus[31:16], refill_bus[31:16]};
	assign wdata_lo = use_cpu_bus ? {^cpu_write_bus, cpu_write_bus}
		: {^refill_bus[15:0], refill_bus[15:0]};

	// ==================================================
	// data sets and tags, one copy per set
	for (genvar s = 0; s < 2; s++) begin : g_set
		logic [16:0]        up_mem  [0:DSET_DEPTH-1];
		logic [16:0]        lo_mem  [0:DSET_DEPTH-1];
		logic [TAG_W-1:0]   tag_mem [0:BLOCKS-1];
		logic [BLOCKS-1:0]  valid_reg;
		logic [BLOCKS-1:0]  dirty_reg;

		assign hit[s] = valid_reg[index] & (tag_mem[index] == tag_in);
		assign blk_dirty[s] = valid_reg[index] & dirty_reg[index];
		assign rd_up[s] = up_mem[ram_addr];
		assign rd_lo[s] = lo_mem[ram_addr];
		// R01: reads leave enables high; bit 31 picks the lower word
		// R12: receive writes both halves of the victim set
		assign up_we_n[s] = ~((wr_hit_go & (hit_set == 1'(s)) & ~cpu_addr[WORD_SEL])
			| (fill_go & (victim_set == 1'(s))));
		assign lo_we_n[s] = ~((wr_hit_go & (hit_set == 1'(s)) & cpu_addr[WORD_SEL])
			| (fill_go & (victim_set == 1'(s))));

		always_ff @(posedge aclk) begin
			if (!up_we_n[s]) begin
				up_mem[ram_addr] <= wdata_up;
			end
			if (!lo_we_n[s]) begin
				lo_mem[ram_addr] <= wdata_lo;
			end
		end

		always_ff @(posedge aclk) begin
			if (fill_go && victim_set == 1'(s)) begin
				tag_mem[index] <= tag_in;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				valid_reg <= '0;
				dirty_reg <= '0;
			end else if (fill_go && victim_set == 1'(s)) begin
				// R17: block becomes present as its words arrive
				valid_reg[index] <= 1'b1;
				dirty_reg[index] <= 1'b0;
			end else if (wr_hit_go && hit_set == 1'(s)) begin
				// R25: written block now differs from memory
				dirty_reg[index] <= 1'b1;
			end else if (state_reg == send_block_state && word_cnt_reg == WORD_CNT_LAST
				&& wb_sel_reg == (s == 0)) begin
				dirty_reg[index] <= 1'b0;
			end
		end
	end

	assign set_a_upper_write_en_n = up_we_n[0];
	assign set_a_lower_write_en_n = lo_we_n[0];
	assign set_b_upper_write_en_n = up_we_n[1];
	assign set_b_lower_write_en_n = lo_we_n[1];

	// ==================================================
	// controller sequence
	// R16: terminal on the last counted word
	assign word_count_terminal = (word_cnt_reg == WORD_CNT_LAST)
		& ((state_reg == send_block_state) | refill_word_strobe);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= cache_idle_state;
		end else begin
			unique case (state_reg)
				cache_idle_state: begin
					// R09: a miss with start held leaves idle
					// R18: after a refill the held access hits here
					if (cpu_start && miss) begin
						state_reg <= wait_for_bus_state;
					end
				end
				wait_for_bus_state: begin
					// R21: dirty victim goes to send first
					// R11: clean victim goes to receive
					// R13: no refill timing is assumed after the grant
					if (bus_grant_ack) begin
						state_reg <= victim_dirty ? send_block_state
							: receive_block_state;
					end
				end
				// R19: both transfers return to idle when done
				receive_block_state, send_block_state: begin
					if (word_count_terminal) begin
						state_reg <= cache_idle_state;
					end
				end
			endcase
		end
	end

	// R16: counter for refill and write-back words
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == wait_for_bus_state) begin
			word_cnt_reg <= 2'h0;
		end else if (refill_word_strobe || state_reg == send_block_state) begin
			word_cnt_reg <= word_cnt_reg + 2'h1;
		end
	end

	// R08: fail stays high while start is held on an unserved access
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_reg <= 1'b0;
		end else begin
			fail_reg <= cpu_start & (~in_idle | miss);
		end
	end
	assign cpu_fail = fail_reg;

	// recency: a hit makes the other set least recent; a fill likewise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lru_a_reg <= '1;
		end else if (do_access) begin
			lru_a_reg[index] <= hit_set;
		end else if (fill_go && word_count_terminal) begin
			lru_a_reg[index] <= victim_set;
		end
	end

	// R22: on entering send the select points at the dirty block's set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wb_sel_reg <= 1'b0;
		end else if (state_reg == wait_for_bus_state && bus_grant_ack && victim_dirty) begin
			wb_sel_reg <= ~victim_set;
		end
	end
	assign writeback_set_select = wb_sel_reg;

	// R20: opcode follows victim state while waiting for the bus
	always_comb begin
		bus_op = bus_op_none;
		if (state_reg == wait_for_bus_state) begin
			// R09: clean miss asks for a private block read
			bus_op = victim_dirty ? write_old_block_op : read_block_private_op;
		end
	end
	assign wake_req_n = (state_reg != wait_for_bus_state);

	// R10: address out in wait-for-bus; old block words out in send
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outgoing_data        <= '0;
			writeback_word_valid <= 1'b0;
		end else begin
			writeback_word_valid <= (state_reg == send_block_state);
			if (state_reg == wait_for_bus_state) begin
				outgoing_data <= {cpu_addr[0:TAG_FIRST-1], cpu_addr[TAG_FIRST:TAG_LAST],
					cpu_addr[INDEX_FIRST:WORD_SEL]};
			end else if (state_reg == send_block_state) begin
				outgoing_data <= wb_sel_reg ? {rd_up[0][15:0], rd_lo[0][15:0]}
					: {rd_up[1][15:0], rd_lo[1][15:0]};
			end else begin
				outgoing_data <= '0;
			end
		end
	end

	// R03: bit ten of the intra-cache address picks the lower word
	assign word_out = cpu_addr[WORD_SEL] ? rd_lo[hit_set] : rd_up[hit_set];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_read_bus     <= '0;
			cpu_parity_error <= 1'b0;
			cache_error      <= 1'b0;
		end else begin
			if (do_access && !cpu_write) begin
				cpu_read_bus <= word_out[15:0];
			end
			// R04: stored even parity must still agree on the way out
			cpu_parity_error <= do_access & ~cpu_write & parity_en_reg & (^word_out);
			// R24: double match reported while an access is pending
			cache_error <= cpu_start & in_idle & dual_hit;
		end
	end

	// ==================================================
	// register bus
	logic                  aw_held_reg;
	logic                  w_held_reg;
	logic [AXI_ADDR_W-1:0] awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  wr_commit;
	logic [31:0]           rd_word;
	logic                  rd_hit;

	assign s_axi_awready = ~aw_held_reg;
	assign s_axi_wready  = ~w_held_reg;
	assign wr_commit = aw_held_reg & w_held_reg & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= '0;
			wstrb_reg    <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_commit) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_reg[AXI_ADDR_W-1:2] <= OFF_MISSES[AXI_ADDR_W-1:2])
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			parity_en_reg <= CTRL_PARITY_RESET;
		end else if (wr_commit && awaddr_reg[AXI_ADDR_W-1:2] == OFF_CTRL[AXI_ADDR_W-1:2]
			&& wstrb_reg[0]) begin
			parity_en_reg <= wdata_reg[CTRL_PARITY_EN];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_cnt_reg  <= '0;
			miss_cnt_reg <= '0;
		end else begin
			if (do_access) begin
				hit_cnt_reg <= hit_cnt_reg + 32'h1;
			end
			if (in_idle && cpu_start && miss) begin
				miss_cnt_reg <= miss_cnt_reg + 32'h1;
			end
		end
	end

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr[AXI_ADDR_W-1:2])
			OFF_CTRL[AXI_ADDR_W-1:2]: rd_word[CTRL_PARITY_EN] = parity_en_reg;
			OFF_STATUS[AXI_ADDR_W-1:2]: begin
				rd_word[STAT_STATE_LSB+:2] = state_reg;
				rd_word[STAT_CNT_LSB+:2]   = word_cnt_reg;
				rd_word[STAT_FAIL]         = fail_reg;
				rd_word[STAT_PAR_ERR]      = cpu_parity_error;
				rd_word[STAT_DUAL_HIT]     = cache_error;
			end
			OFF_HITS[AXI_ADDR_W-1:2]:   rd_word = hit_cnt_reg;
			OFF_MISSES[AXI_ADDR_W-1:2]: rd_word = miss_cnt_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : cache_hit_fault_sequencer

// ---- tb/cache_seq_checker.sv ----
`timescale 1ns/1ps
// =====
// protocol checks on the sequencer ports
module cache_seq_checker
	import cache_seq_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          cpu_start,
	input wire logic          cpu_write,
	input wire logic [0:31]   cpu_addr,
	input wire logic          cpu_fail,
	input wire logic          bus_grant_ack,
	input wire logic          refill_word_ready,
	input wire bus_op_t       bus_op,
	input wire logic          wake_req_n,
	input wire logic [0:31]   outgoing_data,
	input wire logic          writeback_word_valid,
	input wire logic          interface_reg_output_enable_n,
	input wire logic          refill_word_strobe,
	input wire logic          word_count_terminal,
	input wire logic          set_a_upper_write_en_n,
	input wire logic          set_a_lower_write_en_n,
	input wire logic          set_b_upper_write_en_n,
	input wire logic          set_b_lower_write_en_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_read_no_write: assert property (cpu_start && !cpu_write && !cpu_fail |->
		set_a_upper_write_en_n && set_a_lower_write_en_n && set_b_upper_write_en_n
		&& set_b_lower_write_en_n) else $error("write enable active during read");
	a_lower_cause: assert property ((!set_a_lower_write_en_n && set_a_upper_write_en_n)
		|-> cpu_write && cpu_addr[31]) else $error("lower enable without lower write");
	a_wake_op: assert property (!wake_req_n |-> bus_op != bus_op_none)
		else $error("wake request without bus op");
	a_miss_fails: assert property ($fell(wake_req_n) |-> cpu_fail)
		else $error("bus request without fail");
	a_addr_out: assert property (!wake_req_n && !$past(wake_req_n)
		|-> outgoing_data == cpu_addr) else $error("request address wrong");
	a_clean_grant: assert property (!wake_req_n && bus_grant_ack
		&& bus_op == read_block_private_op |=> wake_req_n) else $error("grant not taken");
	a_dirty_grant: assert property (!wake_req_n && bus_grant_ack
		&& bus_op == write_old_block_op |=> wake_req_n ##[1:2] writeback_word_valid)
		else $error("write-back did not start");
	a_strobe_src: assert property (refill_word_strobe |-> refill_word_ready
		&& !interface_reg_output_enable_n) else $error("strobe without ready");
	a_refill_we: assert property (refill_word_strobe |->
		(!set_a_upper_write_en_n && !set_a_lower_write_en_n)
		|| (!set_b_upper_write_en_n && !set_b_lower_write_en_n))
		else $error("refill word not written");
	a_term_idle: assert property (refill_word_strobe && word_count_terminal
		|=> !refill_word_strobe && wake_req_n) else $error("refill ran past last word");
	a_wb_four: assert property ($rose(writeback_word_valid) |->
		writeback_word_valid[*4] ##1 !writeback_word_valid) else $error("write-back not 4 words");
endmodule : cache_seq_checker

// ---- tb/bus_unit_model.sv ----
`timescale 1ns/1ps
// =====
// bus interface unit: grants, then streams a refill block for a read-block-private op
module bus_unit_model
	import cache_seq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        wake_req_n,
	input  wire bus_op_t     bus_op,
	input  wire logic        slow,
	output logic             bus_grant_ack,
	output logic             refill_word_ready,
	output logic [31:0]      refill_bus
);
	bus_op_t    op;
	logic [3:0] n;

	initial begin
		bus_grant_ack = 1'b0;
		refill_word_ready = 1'b0;
		refill_bus = 32'h0;
		n = 4'h0;
		forever begin
			@(negedge aclk);
			if (wake_req_n === 1'b0) begin
				op = bus_op;
				repeat (slow ? 12 : 1) @(posedge aclk);
				bus_grant_ack <= 1'b1;
				do @(negedge aclk); while (wake_req_n === 1'b0);
				@(posedge aclk);
				bus_grant_ack <= 1'b0;
				if (op == read_block_private_op) begin
					repeat (9) @(posedge aclk);
					for (int k = 0; k < 4; k++) begin
						refill_word_ready <= 1'b1;
						refill_bus <= {4'hA, n, 4'h0, k[3:0], 4'h5, n, 4'h0, k[3:0]};
						@(posedge aclk);
					end
					refill_word_ready <= 1'b0;
					// released bus shows inverted data, never a stale word
					refill_bus <= ~refill_bus;
					n++;
				end
			end
		end
	end
endmodule : bus_unit_model

// ---- tb/cache_hit_fault_sequencer_tb.sv ----
`timescale 1ns/1ps
module cache_hit_fault_sequencer_tb;
	import cache_seq_pkg::*;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, refill_bus, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, cpu_sample_clock, cpu_start, cpu_write, cpu_fail;
	logic        cpu_parity_error, cache_error, bus_grant_ack, refill_word_ready, slow;
	logic        wake_req_n, writeback_word_valid, writeback_set_select, word_count_terminal;
	logic        interface_reg_output_enable_n, refill_word_strobe;
	logic        set_a_upper_write_en_n, set_a_lower_write_en_n;
	logic        set_b_upper_write_en_n, set_b_lower_write_en_n;
	logic [0:31] cpu_addr, outgoing_data;
	logic [15:0] cpu_write_bus, cpu_read_bus;
	bus_op_t     bus_op;
	int          mismatches = 0, total_checks = 0, wb_cnt = 0, err_cnt = 0;

	cache_hit_fault_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_sample_clock,
		.cpu_start, .cpu_write, .cpu_addr, .cpu_write_bus, .cpu_read_bus, .cpu_fail,
		.cpu_parity_error, .cache_error, .bus_grant_ack, .refill_word_ready, .refill_bus,
		.bus_op, .wake_req_n, .outgoing_data, .writeback_word_valid, .writeback_set_select,
		.interface_reg_output_enable_n, .refill_word_strobe, .word_count_terminal,
		.set_a_upper_write_en_n, .set_a_lower_write_en_n, .set_b_upper_write_en_n,
		.set_b_lower_write_en_n);
	bus_unit_model partner (.aclk, .wake_req_n, .bus_op, .slow, .bus_grant_ack,
		.refill_word_ready, .refill_bus);

	initial aclk = 1'b0;
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (writeback_word_valid === 1'b1)
			wb_cnt <= wb_cnt + 1;
		if (aresetn === 1'b1 && (cpu_parity_error !== 1'b0 || cache_error !== 1'b0))
			err_cnt <= err_cnt + 1;
	end

	// =====
	// helpers
	function automatic logic [0:31] mk(input logic [15:0] tag, input logic [1:0] w, input logic s);
		mk = '0;
		mk[5:20] = tag;
		mk[21:28] = 8'h3C;
		mk[29:30] = w;
		mk[31] = s;
	endfunction : mk

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask : chk

	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, ta, tw;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(negedge aclk);
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			aw = aw && !ta;
			w = w && !tw;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	// cpu holds start, write and address frozen until fail is low, then one sample edge
	task cpu_acc(input logic wr, input logic [0:31] a, input logic [15:0] wd, input logic [15:0] e);
		int n;
		@(posedge aclk);
		cpu_start <= 1'b1;
		cpu_write <= wr;
		cpu_addr <= a;
		cpu_write_bus <= wd;
		repeat (3) @(posedge aclk);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (cpu_fail !== 1'b0 && n < 5000);
		@(posedge aclk);
		cpu_sample_clock <= 1'b1;
		repeat (6) @(posedge aclk);
		if (!wr) chk("cpu_read_bus", {16'h0, e}, {16'h0, cpu_read_bus});
		cpu_start <= 1'b0;
		cpu_sample_clock <= 1'b0;
		@(posedge aclk);
	endtask : cpu_acc

	// =====
	// main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, cpu_sample_clock, cpu_start} = '0;
		{cpu_write, cpu_addr, cpu_write_bus, slow, aresetn} = '0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(OFF_CTRL, RESP_OKAY);
		chk("ctrl reset", 32'h1, rd);
		axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
		axi_rd(OFF_CTRL, RESP_OKAY);
		chk("ctrl", 32'h0, rd);
		axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
		axi_wr(8'h40, 32'h5, RESP_SLVERR);
		axi_rd(8'h40, RESP_SLVERR);
		cpu_acc(1'b0, mk(16'h1111, 2'h2, 1'b1), 16'h0, 16'h5002);
		cpu_acc(1'b1, mk(16'h1111, 2'h2, 1'b1), 16'hBEEF, 16'h0);
		cpu_acc(1'b0, mk(16'h1111, 2'h2, 1'b1), 16'h0, 16'hBEEF);
		cpu_acc(1'b0, mk(16'h1111, 2'h1, 1'b0), 16'h0, 16'hA001);
		slow <= 1'b1;
		cpu_acc(1'b0, mk(16'h2222, 2'h3, 1'b1), 16'h0, 16'h5103);
		chk("clean write-back words", 32'h0, wb_cnt);
		slow <= 1'b0;
		cpu_acc(1'b0, mk(16'h3333, 2'h0, 1'b0), 16'h0, 16'hA200);
		chk("dirty write-back words", 32'h4, wb_cnt);
		chk("writeback set", 32'h1, {31'h0, writeback_set_select});
		cpu_acc(1'b0, mk(16'h2222, 2'h3, 1'b1), 16'h0, 16'h5103);
		axi_rd(OFF_STATUS, RESP_OKAY);
		chk("idle status", 32'h0, {29'h0, rd[STAT_FAIL], rd[1:0]});
		axi_rd(OFF_HITS, RESP_OKAY);
		chk("hit count", 32'h7, rd);
		chk("error flags", 32'h0, err_cnt);
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		stop_test();
	end
endmodule : cache_hit_fault_sequencer_tb

bind cache_hit_fault_sequencer cache_seq_checker u_chk (.aclk, .aresetn, .cpu_start, .cpu_write,
	.cpu_addr, .cpu_fail, .bus_grant_ack, .refill_word_ready, .bus_op, .wake_req_n,
	.outgoing_data, .writeback_word_valid, .interface_reg_output_enable_n, .refill_word_strobe,
	.word_count_terminal, .set_a_upper_write_en_n, .set_a_lower_write_en_n,
	.set_b_upper_write_en_n, .set_b_lower_write_en_n);
